// *** design/tbas_pkg.sv ***
package tbas_pkg;
   // first byte of a 10-bit address: 11110 a9 a8 rw
   localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;
   localparam int ADDR_W = 10;
   localparam int BYTE_W = 8;
   localparam int BIT_CNT_W = 4;
   localparam logic [3:0] ACK_SLOT = 4'h8;
   localparam logic [9:0] OWN_ADDR_RST = 10'h002;
   typedef enum logic [2:0] {
      TBAS_IDLE = 3'b000,
      TBAS_HI   = 3'b001,
      TBAS_LO   = 3'b011,
      TBAS_DATA = 3'b010,
      TBAS_RD   = 3'b110,
      TBAS_SKIP = 3'b111
   } tbas_state_e;
endpackage

// *** design/tbas_slave.sv ***
`timescale 1ns/1ps
`default_nettype none
module tbas_slave #(
   parameter int ADDR_W = tbas_pkg::ADDR_W
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_enable,
   input wire logic [ADDR_W-1:0] i_own_addr,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic i_rx_read,
   input wire logic i_acknowledge_status_bit_clear,
   input wire logic [7:0] i_tx_data,
   output logic o_sda_out,
   output logic o_sda_oe_n,
   output logic [7:0] o_receive_holding_register,
   output logic o_receive_full_flag,
   output logic o_acknowledge_status_bit,
   output logic o_addressed,
   output logic o_port_scl,
   output logic o_port_sda
);
   tbas_pkg::tbas_state_e state, next_state;
   logic scl_q, sda_q, next_scl_q, next_sda_q;
   logic [7:0] shreg, next_shreg, tx_sh, next_tx_sh;
   logic [3:0] bit_cnt, next_bit_cnt;
   logic ack_phase, next_ack_phase;
   logic [7:0] rcv, next_rcv;
   logic receive_full_flag, next_rbf, acknowledge_status_bit, next_acknowledge_status_bit;
   logic sda_drv, next_sda_drv, addressed, next_addressed;
   logic sda_oe_n, next_sda_oe_n;
   logic hdr_match, lo_match;
   logic pscl, psda, next_pscl, next_psda;
   logic scl_rise, scl_fall, start_c, stop_c;
   logic [7:0] byte_in;

   // edges come from the previous sample; the pins already sit in this clock domain
   assign scl_rise = i_scl & ~scl_q;
   assign scl_fall = ~i_scl & scl_q;
   // start and stop want scl high on both samples, so an sda move beside an scl edge is ignored
   assign start_c = i_scl & scl_q & sda_q & ~i_sda;
   assign stop_c = i_scl & scl_q & ~sda_q & i_sda;
   assign byte_in = {shreg[6:0], i_sda};
   assign hdr_match = shreg[7:3] == tbas_pkg::TEN_BIT_PREFIX && shreg[2:1] == i_own_addr[9:8];
   assign lo_match = shreg == i_own_addr[7:0];

   always_comb begin
      next_scl_q = i_scl;
      next_sda_q = i_sda;
      next_state = state;
      next_shreg = shreg;
      next_tx_sh = tx_sh;
      next_bit_cnt = bit_cnt;
      next_ack_phase = ack_phase;
      next_rcv = rcv;
      next_rbf = receive_full_flag;
      next_acknowledge_status_bit = acknowledge_status_bit;
      next_sda_drv = sda_drv;
      next_addressed = addressed;
      // real pin levels always, even with the controller enabled
      next_pscl = i_scl;
      next_psda = i_sda;
      // software clears first, so a set later in this process wins the same cycle
      if (i_rx_read) begin
         next_rbf = 1'b0;
      end
      if (i_acknowledge_status_bit_clear) begin
         next_acknowledge_status_bit = 1'b0;
      end
      // disable lets go of the bus at once; the flags stay for software
      if (!i_enable) begin
         next_state = tbas_pkg::TBAS_IDLE;
         next_sda_drv = 1'b0;
         next_addressed = 1'b0;
      end else if (start_c) begin
         // start does not touch acknowledge status
         next_state = tbas_pkg::TBAS_HI;
         next_bit_cnt = '0;
         next_ack_phase = 1'b0;
         next_sda_drv = 1'b0;
         // a repeated start keeps the match, so the read header that follows can be answered
      end else if (stop_c) begin
         next_state = tbas_pkg::TBAS_IDLE;
         next_sda_drv = 1'b0;
         next_addressed = 1'b0;
      end else if (state != tbas_pkg::TBAS_IDLE && scl_rise) begin
         if (ack_phase) begin
            if (state == tbas_pkg::TBAS_RD && i_sda) begin
               // master nack: set wins over a same-cycle clear
               next_acknowledge_status_bit = 1'b1;
               next_state = tbas_pkg::TBAS_SKIP;
            end
         end else if (state == tbas_pkg::TBAS_RD) begin
            next_bit_cnt = bit_cnt + 4'h1;
         end else begin
            next_shreg = byte_in;
            next_bit_cnt = bit_cnt + 4'h1;
         end
      end else if (state != tbas_pkg::TBAS_IDLE && scl_fall) begin
         if (ack_phase) begin
            next_ack_phase = 1'b0;
            next_bit_cnt = '0;
            next_sda_drv = 1'b0;
            if (state == tbas_pkg::TBAS_RD) begin
               next_tx_sh = {i_tx_data[6:0], 1'b0};
               next_sda_drv = ~i_tx_data[7];
            end
         end else if (bit_cnt == tbas_pkg::ACK_SLOT) begin
            // the eighth falling edge opens the acknowledge slot
            next_ack_phase = 1'b1;
            next_sda_drv = 1'b0;
            unique case (state)
               tbas_pkg::TBAS_HI: begin
                  // any new header drops an earlier match, except a read of the same address
                  next_addressed = 1'b0;
                  // prefix plus top two bits; read after an earlier match
                  if (hdr_match) begin
                     if (shreg[0] && addressed) begin
                        next_state = tbas_pkg::TBAS_RD;
                        next_addressed = 1'b1;
                     end else if (!shreg[0]) begin
                        next_state = tbas_pkg::TBAS_LO;
                     end else begin
                        next_state = tbas_pkg::TBAS_SKIP;
                     end
                     next_sda_drv = ~shreg[0] | addressed;
                  end else begin
                     next_state = tbas_pkg::TBAS_SKIP;
                  end
               end
               tbas_pkg::TBAS_LO: begin
                  if (lo_match) begin
                     next_sda_drv = 1'b1;
                     // no reserved-pattern exceptions: any match loads
                     next_rcv = shreg;
                     next_rbf = 1'b1;
                     next_addressed = 1'b1;
                     next_state = tbas_pkg::TBAS_DATA;
                  end else begin
                     next_state = tbas_pkg::TBAS_SKIP;
                  end
               end
               tbas_pkg::TBAS_DATA: begin
                  next_rcv = shreg;
                  next_rbf = 1'b1;
                  next_sda_drv = 1'b1;
               end
               tbas_pkg::TBAS_RD, tbas_pkg::TBAS_SKIP: begin
               end
               default: begin
                  next_state = tbas_pkg::TBAS_IDLE;
               end
            endcase
         end else if (state == tbas_pkg::TBAS_RD) begin
            // open drain: only pull low, wire-AND with any other talker
            next_sda_drv = ~tx_sh[7];
            next_tx_sh = {tx_sh[6:0], 1'b0};
         end
      end
      // the pin enable gets a flop of its own, so no gate sits between register and pin
      next_sda_oe_n = ~next_sda_drv;
   end

   // one register stage for all state; reset leaves the bus released
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state <= tbas_pkg::TBAS_IDLE;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         shreg <= '0;
         tx_sh <= '0;
         bit_cnt <= '0;
         ack_phase <= 1'b0;
         rcv <= '0;
         receive_full_flag <= 1'b0;
         acknowledge_status_bit <= 1'b0;
         sda_drv <= 1'b0;
         sda_oe_n <= 1'b1;
         addressed <= 1'b0;
         pscl <= 1'b1;
         psda <= 1'b1;
      end else begin
         state <= next_state;
         scl_q <= next_scl_q;
         sda_q <= next_sda_q;
         shreg <= next_shreg;
         tx_sh <= next_tx_sh;
         bit_cnt <= next_bit_cnt;
         ack_phase <= next_ack_phase;
         rcv <= next_rcv;
         receive_full_flag <= next_rbf;
         acknowledge_status_bit <= next_acknowledge_status_bit;
         sda_drv <= next_sda_drv;
         sda_oe_n <= next_sda_oe_n;
         addressed <= next_addressed;
         pscl <= next_pscl;
         psda <= next_psda;
      end
   end

   // open drain: the data value is always low, only the enable moves
   assign o_sda_out = 1'b0;
   assign o_sda_oe_n = sda_oe_n;
   assign o_receive_holding_register = rcv;
   assign o_receive_full_flag = receive_full_flag;
   assign o_acknowledge_status_bit = acknowledge_status_bit;
   assign o_addressed = addressed;
   assign o_port_scl = pscl;
   assign o_port_sda = psda;
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
   logic clk = 1'b0, rst = 1'b1, en = 1'b1, rd = 1'b0, clr = 1'b0;
   logic [9:0] own = 10'h002;
   logic [7:0] tx = 8'h00, r;
   logic [31:0] seed = 32'h0000_3DEA;
   logic a_n;
   wire logic oe_n, sda_o, scl, sda, receive_full_flag, ackst;
   wire logic adr, pscl, psda;
   wire logic [7:0] rcv;
   int mismatches = 0, compares = 0;
   initial forever #10 clk = ~clk;
   tbas_slave dut (.i_clk(clk), .i_rst(rst), .i_enable(en), .i_own_addr(own), .i_scl(scl), .i_sda(sda), .i_rx_read(rd),
      .i_acknowledge_status_bit_clear(clr), .i_tx_data(tx), .o_sda_out(sda_o), .o_sda_oe_n(oe_n), .o_receive_holding_register(rcv),
      .o_receive_full_flag(receive_full_flag), .o_acknowledge_status_bit(ackst), .o_addressed(adr),
      .o_port_scl(pscl), .o_port_sda(psda));
   tbas_agent bus (.i_clk(clk), .i_oe_n(oe_n), .i_out(sda_o), .o_scl(scl), .o_sda(sda));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      return s ^ (s << 5);
   endfunction
   function automatic logic [7:0] hdr(input logic [9:0] a, input logic rw);
      return {tbas_pkg::TEN_BIT_PREFIX, a[9:8], rw};
   endfunction
   // random picks keep the low byte clear of reserved seven-bit forms
   function automatic logic [9:0] pick(input logic [9:0] a);
      if (a[7:4] == 4'h0 || a[7:4] == 4'hf) begin
         a[6] = ~a[6];
      end
      return a;
   endfunction
   task automatic pulse(ref logic s);
      s = 1'b1;
      bus.tick(1);
      s = 1'b0;
   endtask
   task automatic conclude();
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      #1_000_000;
      mismatches++;
      conclude();
   end
   initial begin
      bus.tick(6);
      rst = 1'b0;
      // first four are reserved look-alike low bytes
      for (int k = 0; k < 12; k++) begin
         seed = xs(seed);
         own = k == 0 ? 10'h002 : k == 1 ? 10'h0F1 : k == 2 ? 10'h30F : k == 3 ? 10'h1F5 : pick(seed[9:0]);
         tx = seed[23:16];
         bus.cond(1'b1, 1'b0);
         `CHK({pscl, psda}, {scl, sda})
         bus.xfer(hdr(own ^ 10'h100, 1'b0), 1'b1, r, a_n);
         `CHK(a_n, 1'b1)
         bus.cond(1'b1, 1'b0);
         bus.xfer(hdr(own, 1'b0), 1'b1, r, a_n);
         `CHK(a_n, 1'b0)
         bus.xfer(own[7:0], 1'b1, r, a_n);
         `CHK({a_n, receive_full_flag, rcv}, {2'b01, own[7:0]})
         `CHK(adr, 1'b1)
         pulse(rd);
         `CHK(receive_full_flag, 1'b0)
         bus.cond(1'b1, 1'b0);
         bus.xfer(hdr(own, 1'b1), 1'b1, r, a_n);
         `CHK(a_n, 1'b0)
         `CHK(adr, 1'b1)
         bus.xfer(seed[31:24], 1'b1, r, a_n);
         `CHK(r, seed[31:24] & tx)
         `CHK(ackst, 1'b1)
         bus.cond(1'b0, 1'b1);
         `CHK(ackst, 1'b1)
         `CHK(adr, 1'b0)
         `CHK({pscl, psda}, {scl, sda})
         pulse(clr);
         `CHK(ackst, 1'b0)
         $display("test %0d done", k);
      end
      bus.cond(1'b1, 1'b0);
      bus.xfer(hdr(own, 1'b1), 1'b1, r, a_n);
      `CHK(a_n, 1'b1)
      bus.cond(1'b0, 1'b1);
      $display("unmatched read test done");
      en = 1'b0;
      bus.cond(1'b1, 1'b0);
      bus.xfer(hdr(own, 1'b0), 1'b1, r, a_n);
      `CHK(a_n, 1'b1)
      bus.cond(1'b0, 1'b1);
      en = 1'b1;
      $display("disable test done");
      conclude();
   end
endmodule
`default_nettype wire

// *** sim/tbas_agent.sv ***
`timescale 1ns/1ps
`default_nettype none
// bus master agent with no slave address of its own, so it never answers a header
module tbas_agent (
   input wire logic i_clk,
   input wire logic i_oe_n,
   input wire logic i_out,
   output logic o_scl,
   output logic o_sda
);
   logic m_sda = 1'b1;
   logic t;
   initial o_scl = 1'b1;
   // pulled-up wire: whoever pulls low wins
   assign o_sda = m_sda & (i_oe_n | i_out);
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #2;
   endtask
   task automatic put(input logic b, output logic r);
      m_sda = b;
      tick(2);
      o_scl = 1'b1;
      tick(2);
      r = o_sda;
      o_scl = 1'b0;
      tick(2);
   endtask
   // (1,0) gives a start, (0,1) a stop
   task automatic cond(input logic a, input logic b);
      m_sda = a;
      tick(2);
      o_scl = 1'b1;
      tick(2);
      m_sda = b;
      tick(2);
      o_scl = b;
      tick(2);
   endtask
   task automatic xfer(input logic [7:0] w, input logic a, output logic [7:0] r, output logic ack_n);
      for (int i = 7; i >= 0; i--) begin
         put(w[i], t);
         r = {r[6:0], t};
      end
      put(a, ack_n);
   endtask
endmodule
`default_nettype wire

// *** sim/tbas_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module tbas_props #(parameter int ADDR_W = 10) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_enable,
   input wire logic [ADDR_W-1:0] i_own_addr,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic i_rx_read,
   input wire logic i_acknowledge_status_bit_clear,
   input wire logic o_sda_out,
   input wire logic o_sda_oe_n,
   input wire logic [7:0] o_receive_holding_register,
   input wire logic o_receive_full_flag,
   input wire logic o_acknowledge_status_bit,
   input wire logic o_addressed,
   input wire logic o_port_scl,
   input wire logic o_port_sda
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   a_scl_copy: assert property (!$past(i_rst) |-> o_port_scl == $past(i_scl)) else $error("scl copy");
   a_sda_copy: assert property (!$past(i_rst) |-> o_port_sda == $past(i_sda)) else $error("sda copy");
   a_open_drain: assert property (o_sda_out == 1'b0 && (o_sda_oe_n || $past(i_enable))) else $error("sda drive");
   a_nack_sticky: assert property (o_acknowledge_status_bit && !i_acknowledge_status_bit_clear
      |=> o_acknowledge_status_bit) else $error("acknowledge_status_bit lost");
   a_full_holds: assert property (o_receive_full_flag && !i_rx_read |=> o_receive_full_flag)
      else $error("full flag lost");
   a_match_load: assert property ($rose(o_addressed) |-> o_receive_full_flag
      && o_receive_holding_register == i_own_addr[7:0]) else $error("match load");
   a_match_ack: assert property ($rose(o_addressed) |-> !o_sda_oe_n) else $error("match ack");
   a_off_idle: assert property (!i_enable |=> o_sda_oe_n && !o_addressed) else $error("idle");
   c_match: cover property ($rose(o_addressed));
   c_nack: cover property ($rose(o_acknowledge_status_bit));
   c_reen: cover property (!i_enable ##1 i_enable);
endmodule
bind tbas_slave tbas_props #(.ADDR_W(ADDR_W)) u_props (.i_clk, .i_rst, .i_enable, .i_own_addr, .i_scl, .i_sda,
   .i_rx_read, .i_acknowledge_status_bit_clear, .o_sda_out, .o_sda_oe_n, .o_receive_holding_register, .o_receive_full_flag,
   .o_acknowledge_status_bit, .o_addressed, .o_port_scl, .o_port_sda);
`default_nettype wire
